// file: rtl/mcl_pkg.sv
package mcl_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0]  MCL_CFG_A_OFS   = 8'h00;
    localparam logic [7:0]  MCL_STATUS_OFS  = 8'h04;
    localparam logic [31:0] MCL_CFG_A_RST   = 32'h0000_0000;
    localparam logic [31:0] MCL_CFG_A_WMASK = 32'h7FFF_FFFE;
    localparam logic [31:0] MCL_UNMAPPED_RD = 32'h0000_0000;

    // ****************************************************************
    // field codes
    // ****************************************************************
    localparam logic [4:0] MCL_RATE_NOLIMIT   = 5'h1F;
    localparam logic [3:0] MCL_FREQ_MIN_CODE  = 4'h1;
    localparam logic [3:0] MCL_FREQ_MAX_CODE  = 4'hA;
    localparam logic [6:0] MCL_FREQ_BASE_KHZ  = 7'h0A;
    localparam logic [6:0] MCL_FREQ_STEP_KHZ  = 7'h05;
    localparam logic [1:0] MCL_PHASE_BOTH     = 2'h0;
    localparam logic [1:0] MCL_PHASE_CLOSED   = 2'h1;
    localparam logic [1:0] MCL_PHASE_FIRST    = 2'h2;
    localparam logic [2:0] MCL_THR_MAX_CODE   = 3'h5;
    localparam logic [3:0] MCL_DIV_MIN        = 4'h2;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        MCL_DEC_FROM_DECEL,
        MCL_DEC_FROM_ACCEL,
        MCL_DEC_BY_SURGE
    } mcl_decel_src_t;

    typedef struct packed {
        logic       rsvd_hi;
        logic       overmod_en;
        logic [4:0] closed_loop_accel_rate;
        logic       decel_source_select;
        logic [4:0] closed_loop_decel_rate;
        logic [3:0] pwm_freq_code;
        logic       pwm_discontinuous;
        logic [1:0] speed_pulse_phase_select;
        logic [3:0] speed_pulse_divider;
        logic       speed_pulse_stop_policy;
        logic [2:0] speed_pulse_backemf_threshold;
        logic       anti_surge_enable;
        logic       deadtime_comp_enable;
        logic       speed_regulator_bypass;
        logic       rsvd_lo;
    } mcl_cfg_t;

    typedef struct packed {
        logic [17:0]    decel_rate_half_hz;
        logic           decel_unlimited;
        mcl_decel_src_t decel_src;
        logic [6:0]     pwm_freq_khz;
        logic           pwm_freq_valid;
        logic           pwm_discontinuous;
        logic           overmod_en;
        logic           anti_surge_enable;
        logic           deadtime_comp_enable;
        logic           speed_regulator_bypass;
    } mcl_ctl_t;

    typedef struct packed {
        logic [7:0]     pad;
        logic           gate_open;
        logic           thr_valid;
        logic           pwm_freq_valid;
        logic           decel_unlimited;
        mcl_decel_src_t decel_src;
        logic [17:0]    decel_rate_half_hz;
    } mcl_stat_t;

    // ramp limit in units of 0.5 Hz/s
    function automatic logic [17:0] mcl_rate_lookup(input logic [4:0] code);
        logic [17:0] r;
        r = 18'h0_0000;
        case (code)
            5'h00: r = 18'h0_0001;
            5'h01: r = 18'h0_0002;
            5'h02: r = 18'h0_0005;
            5'h03: r = 18'h0_000A;
            5'h04: r = 18'h0_000F;
            5'h05: r = 18'h0_0014;
            5'h06: r = 18'h0_0028;
            5'h07: r = 18'h0_0050;
            5'h08: r = 18'h0_0078;
            5'h09: r = 18'h0_00A0;
            5'h0A: r = 18'h0_00C8;
            5'h0B: r = 18'h0_0190;
            5'h0C: r = 18'h0_0258;
            5'h0D: r = 18'h0_0320;
            5'h0E: r = 18'h0_03E8;
            5'h0F: r = 18'h0_04B0;
            5'h10: r = 18'h0_0578;
            5'h11: r = 18'h0_0640;
            5'h12: r = 18'h0_0708;
            5'h13: r = 18'h0_07D0;
            5'h14: r = 18'h0_0FA0;
            5'h15: r = 18'h0_1F40;
            5'h16: r = 18'h0_2EE0;
            5'h17: r = 18'h0_3E80;
            5'h18: r = 18'h0_4E20;
            5'h19: r = 18'h0_9C40;
            5'h1A: r = 18'h0_EA60;
            5'h1B: r = 18'h1_3880;
            5'h1C: r = 18'h1_86A0;
            5'h1D: r = 18'h1_D4C0;
            5'h1E: r = 18'h2_22E0;
            default: r = 18'h0_0000;
        endcase
        return r;
    endfunction : mcl_rate_lookup

    // back-emf window in mV
    function automatic logic [7:0] mcl_thr_lookup(input logic [2:0] code);
        logic [7:0] t;
        t = 8'h00;
        case (code)
            3'h0: t = 8'h01;
            3'h1: t = 8'h02;
            3'h2: t = 8'h05;
            3'h3: t = 8'h0A;
            3'h4: t = 8'h14;
            3'h5: t = 8'h1E;
            default: t = 8'h00;
        endcase
        return t;
    endfunction : mcl_thr_lookup

endpackage : mcl_pkg

// file: rtl/mcl_pulse_div.sv
`timescale 1ns/1ps
`default_nettype none
module mcl_pulse_div (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // pulse path
    input  wire logic       tick_in,
    input  wire logic [3:0] divisor,
    output var  logic       pulse_out
);
    import mcl_pkg::*;

    logic [3:0] count_r;
    logic [3:0] count_nxt;
    logic       pulse_nxt;
    wire  logic [3:0] eff_div = (divisor < MCL_DIV_MIN) ? 4'h1 : divisor;
    wire  logic [3:0] count_inc = count_r + 4'h1;
    wire  logic       wrap = count_inc >= eff_div;

    assign count_nxt = tick_in ? (wrap ? 4'h0 : count_inc) : count_r;
    assign pulse_nxt = tick_in & wrap;

    always_ff @(posedge clk) begin
        if (reset) begin
            count_r   <= 4'h0;
            pulse_out <= 1'b0;
        end else begin
            count_r   <= count_nxt;
            pulse_out <= pulse_nxt;
        end
    end

endmodule : mcl_pulse_div
`default_nettype wire

// file: rtl/mcl_top.sv
`timescale 1ns/1ps
`default_nettype none
module mcl_top (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [31:0]       reg_rdata,
    // motor-control core status
    input  wire logic              speed_tick,
    input  wire logic              loop_closed,
    input  wire logic              first_attempt,
    input  wire logic              motor_driven,
    input  wire logic [7:0]        bemf_mv,
    // motor-control core settings
    output var  mcl_pkg::mcl_ctl_t ctl,
    // speed pulse pin
    output wire logic              speed_pulse_output
);
    import mcl_pkg::*;

    // ****************************************************************
    // register file
    // ****************************************************************
    mcl_cfg_t  cfg_r;
    mcl_cfg_t  cfg_nxt;
    mcl_ctl_t  ctl_nxt;
    mcl_stat_t stat;
    logic [31:0] rdata_nxt;

    wire logic sel_cfg    = reg_addr == MCL_CFG_A_OFS;
    wire logic sel_status = reg_addr == MCL_STATUS_OFS;
    wire logic wr_cfg     = reg_wr & sel_cfg;

    // reserved bits never store
    assign cfg_nxt = wr_cfg ? mcl_cfg_t'(reg_wdata & MCL_CFG_A_WMASK) : cfg_r;

    assign rdata_nxt = !reg_rd     ? 32'h0000_0000 :
                       sel_cfg    ? 32'(cfg_r) :
                       sel_status ? 32'(stat) : MCL_UNMAPPED_RD;

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_r     <= mcl_cfg_t'(MCL_CFG_A_RST);
            reg_rdata <= 32'h0000_0000;
        end else begin
            cfg_r     <= cfg_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    // ****************************************************************
    // deceleration source and rate
    // ****************************************************************
    wire mcl_decel_src_t dec_src =
        cfg_r.decel_source_select ? MCL_DEC_FROM_ACCEL :
        cfg_r.anti_surge_enable   ? MCL_DEC_BY_SURGE   : MCL_DEC_FROM_DECEL;
    wire logic [4:0] dec_code = cfg_r.decel_source_select ?
        cfg_r.closed_loop_accel_rate : cfg_r.closed_loop_decel_rate;
    wire logic dec_field_live = dec_src != MCL_DEC_BY_SURGE;
    wire logic dec_unlimited  = dec_field_live && dec_code == MCL_RATE_NOLIMIT;
    wire logic [17:0] dec_rate = dec_field_live ? mcl_rate_lookup(dec_code)
                                                : 18'h0_0000;

    // ****************************************************************
    // switching frequency
    // ****************************************************************
    wire logic freq_ok = cfg_r.pwm_freq_code >= MCL_FREQ_MIN_CODE &&
                         cfg_r.pwm_freq_code <= MCL_FREQ_MAX_CODE;
    wire logic [6:0] freq_khz = freq_ok ?
        7'(MCL_FREQ_BASE_KHZ + MCL_FREQ_STEP_KHZ * {3'h0, cfg_r.pwm_freq_code})
        : 7'h00;

    // ****************************************************************
    // control bundle to the core
    // ****************************************************************
    always_comb begin
        ctl_nxt                        = '0;
        ctl_nxt.decel_rate_half_hz     = dec_rate;
        ctl_nxt.decel_unlimited        = dec_unlimited;
        ctl_nxt.decel_src              = dec_src;
        ctl_nxt.pwm_freq_khz           = freq_khz;
        ctl_nxt.pwm_freq_valid         = freq_ok;
        ctl_nxt.pwm_discontinuous      = cfg_r.pwm_discontinuous;
        ctl_nxt.overmod_en             = cfg_r.overmod_en;
        ctl_nxt.anti_surge_enable      = cfg_r.anti_surge_enable;
        ctl_nxt.deadtime_comp_enable   = cfg_r.deadtime_comp_enable;
        ctl_nxt.speed_regulator_bypass = cfg_r.speed_regulator_bypass;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctl <= '0;
        end else begin
            ctl <= ctl_nxt;
        end
    end

    // ****************************************************************
    // speed pulse gating
    // ****************************************************************
    logic phase_ok;
    wire logic       thr_ok  = cfg_r.speed_pulse_backemf_threshold <= MCL_THR_MAX_CODE;
    wire logic [7:0] thr_mv  = mcl_thr_lookup(cfg_r.speed_pulse_backemf_threshold);
    wire logic       bemf_hi = thr_ok && bemf_mv >= thr_mv;
    wire logic       run_ok  = motor_driven ||
                               (cfg_r.speed_pulse_stop_policy && bemf_hi);
    wire logic       gate    = phase_ok && run_ok;
    wire logic       tick_g  = speed_tick && gate;

    always_comb begin
        case (cfg_r.speed_pulse_phase_select)
            MCL_PHASE_BOTH:   phase_ok = 1'b1;
            MCL_PHASE_CLOSED: phase_ok = loop_closed;
            MCL_PHASE_FIRST:  phase_ok = loop_closed || first_attempt;
            default:          phase_ok = 1'b0;
        endcase
    end

    mcl_pulse_div u_div (
        .clk       (clk),
        .reset     (reset),
        .tick_in   (tick_g),
        .divisor   (cfg_r.speed_pulse_divider),
        .pulse_out (speed_pulse_output)
    );

    // ****************************************************************
    // status word
    // ****************************************************************
    always_comb begin
        stat                    = '0;
        stat.gate_open          = gate;
        stat.thr_valid          = thr_ok;
        stat.pwm_freq_valid     = freq_ok;
        stat.decel_unlimited    = dec_unlimited;
        stat.decel_src          = dec_src;
        stat.decel_rate_half_hz = dec_rate;
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_cfg_write;
        reg_wr && sel_cfg;
    endsequence

    sequence s_cfg_read;
        reg_rd && sel_cfg;
    endsequence

    property p_readback;
        logic [31:0] d;
        (s_cfg_write, d = reg_wdata) ##1 s_cfg_read |=> reg_rdata == (d & MCL_CFG_A_WMASK);
    endproperty
    a_readback: assert property (p_readback) else $error("config readback wrong");

    property p_rsvd_zero;
        s_cfg_read |=> reg_rdata[0] == 1'b0 && reg_rdata[31] == 1'b0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit reads one");

    property p_decel_src;
        !cfg_r.decel_source_select && cfg_r.anti_surge_enable
            |=> ctl.decel_src == MCL_DEC_BY_SURGE && ctl.decel_rate_half_hz == 18'h0_0000;
    endproperty
    a_decel_src: assert property (p_decel_src) else $error("decel field used under surge");

    property p_accel_src;
        cfg_r.decel_source_select && cfg_r.closed_loop_accel_rate == 5'h00
            |=> ctl.decel_src == MCL_DEC_FROM_ACCEL && ctl.decel_rate_half_hz == 18'h0_0001;
    endproperty
    a_accel_src: assert property (p_accel_src) else $error("decel not from accel field");

    property p_nolimit;
        !cfg_r.decel_source_select && !cfg_r.anti_surge_enable &&
        cfg_r.closed_loop_decel_rate == MCL_RATE_NOLIMIT |=> ctl.decel_unlimited;
    endproperty
    a_nolimit: assert property (p_nolimit) else $error("code 1Fh not unlimited");

    property p_rate_top;
        !cfg_r.decel_source_select && !cfg_r.anti_surge_enable &&
        cfg_r.closed_loop_decel_rate == 5'h1E
            |=> ctl.decel_rate_half_hz == 18'h2_22E0 && !ctl.decel_unlimited;
    endproperty
    a_rate_top: assert property (p_rate_top) else $error("top decel rate wrong");

    property p_freq;
        cfg_r.pwm_freq_code == 4'hA |=> ctl.pwm_freq_valid && ctl.pwm_freq_khz == 7'h3C;
    endproperty
    a_freq: assert property (p_freq) else $error("60 kHz decode wrong");

    property p_freq_rsvd;
        cfg_r.pwm_freq_code == 4'h0 || cfg_r.pwm_freq_code > 4'hA |=> !ctl.pwm_freq_valid;
    endproperty
    a_freq_rsvd: assert property (p_freq_rsvd) else $error("reserved frequency valid");

    property p_mode;
        cfg_r.pwm_discontinuous |=> ctl.pwm_discontinuous;
    endproperty
    a_mode: assert property (p_mode) else $error("modulation mode not applied");

    property p_phase_closed;
        cfg_r.speed_pulse_phase_select == MCL_PHASE_CLOSED && !loop_closed
            |=> !speed_pulse_output;
    endproperty
    a_phase_closed: assert property (p_phase_closed) else $error("pulse in open loop");

    property p_div_one;
        speed_tick && gate && cfg_r.speed_pulse_divider <= 4'h1 |=> speed_pulse_output;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one missed");

    property p_div_two;
        speed_pulse_output && cfg_r.speed_pulse_divider == 4'h2 && $stable(cfg_r)
            |=> !speed_pulse_output;
    endproperty
    a_div_two: assert property (p_div_two) else $error("divide by two too fast");

    property p_stop_driven;
        !cfg_r.speed_pulse_stop_policy && !motor_driven |=> !speed_pulse_output;
    endproperty
    a_stop_driven: assert property (p_stop_driven) else $error("pulse after drive off");

    property p_bemf_thr;
        cfg_r.speed_pulse_stop_policy && !motor_driven &&
        cfg_r.speed_pulse_backemf_threshold == 3'h5 && bemf_mv < 8'h1E
            |=> !speed_pulse_output;
    endproperty
    a_bemf_thr: assert property (p_bemf_thr) else $error("pulse below emf window");

    property p_surge;
        wr_cfg ##1 1'b1 |=> ctl.anti_surge_enable == $past(reg_wdata[3], 2);
    endproperty
    a_surge: assert property (p_surge) else $error("surge enable not applied");

    property p_deadtime;
        cfg_r.deadtime_comp_enable != ctl.deadtime_comp_enable |=> $changed(ctl.deadtime_comp_enable);
    endproperty
    a_deadtime: assert property (p_deadtime) else $error("dead-time enable lag");

    property p_bypass;
        cfg_r.speed_regulator_bypass [*2] |-> ctl.speed_regulator_bypass;
    endproperty
    a_bypass: assert property (p_bypass) else $error("regulator bypass not applied");

    property p_rate_min;
        !cfg_r.decel_source_select && !cfg_r.anti_surge_enable &&
        cfg_r.closed_loop_decel_rate == 5'h00 |=> ctl.decel_rate_half_hz == 18'h0_0001;
    endproperty
    a_rate_min: assert property (p_rate_min) else $error("min rate wrong");

    property p_limited;
        ctl.decel_rate_half_hz != 18'h0_0000 |-> !ctl.decel_unlimited;
    endproperty
    a_limited: assert property (p_limited) else $error("limit flagged unlimited");

    property p_surge_lim;
        cfg_r.anti_surge_enable && !cfg_r.decel_source_select |=> !ctl.decel_unlimited;
    endproperty
    a_surge_lim: assert property (p_surge_lim) else $error("surge kept decel field");

    property p_acc_wins;
        cfg_r.decel_source_select |=> ctl.decel_src == MCL_DEC_FROM_ACCEL;
    endproperty
    a_acc_wins: assert property (p_acc_wins) else $error("select ignored");

    property p_freq_min;
        cfg_r.pwm_freq_code == 4'h1 |=> ctl.pwm_freq_valid && ctl.pwm_freq_khz == 7'h0F;
    endproperty
    a_freq_min: assert property (p_freq_min) else $error("15 kHz decode wrong");

    property p_freq_zero;
        !ctl.pwm_freq_valid |-> ctl.pwm_freq_khz == 7'h00;
    endproperty
    a_freq_zero: assert property (p_freq_zero) else $error("reserved freq nonzero");

    property p_mode_cont;
        !cfg_r.pwm_discontinuous |=> !ctl.pwm_discontinuous;
    endproperty
    a_mode_cont: assert property (p_mode_cont) else $error("continuous mode lost");

    property p_phase_rsvd;
        cfg_r.speed_pulse_phase_select == 2'h3 |=> !speed_pulse_output;
    endproperty
    a_phase_rsvd: assert property (p_phase_rsvd) else $error("pulse on reserved phase");

    property p_phase_first;
        cfg_r.speed_pulse_phase_select == MCL_PHASE_FIRST && !loop_closed && !first_attempt
            |=> !speed_pulse_output;
    endproperty
    a_phase_first: assert property (p_phase_first) else $error("pulse after first try");

    property p_no_tick;
        !speed_tick |=> !speed_pulse_output;
    endproperty
    a_no_tick: assert property (p_no_tick) else $error("pulse without tick");

    property p_thr_rsvd;
        cfg_r.speed_pulse_stop_policy && !motor_driven &&
        cfg_r.speed_pulse_backemf_threshold > MCL_THR_MAX_CODE |=> !speed_pulse_output;
    endproperty
    a_thr_rsvd: assert property (p_thr_rsvd) else $error("reserved window used");

    property p_surge_on;
        cfg_r.anti_surge_enable |=> ctl.anti_surge_enable;
    endproperty
    a_surge_on: assert property (p_surge_on) else $error("surge enable lost");

    property p_dt_on;
        cfg_r.deadtime_comp_enable |=> ctl.deadtime_comp_enable;
    endproperty
    a_dt_on: assert property (p_dt_on) else $error("dead-time enable lost");

    property p_byp_off;
        !cfg_r.speed_regulator_bypass |=> !ctl.speed_regulator_bypass;
    endproperty
    a_byp_off: assert property (p_byp_off) else $error("regulator bypass stuck");

    property p_bit0;
        wr_cfg |=> cfg_r.rsvd_lo == 1'b0 && cfg_r.rsvd_hi == 1'b0;
    endproperty
    a_bit0: assert property (p_bit0) else $error("reserved bit stored");

endmodule : mcl_top
`default_nettype wire

// file: sim/test_motor_closed_loop_config_low.sv
`timescale 1ns/1ps
`default_nettype none
module test_motor_closed_loop_config_low;
    import mcl_pkg::*;

    // ****************************************************************
    // stimulus and design
    // ****************************************************************
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        speed_tick = 1'b0;
    logic        loop_closed = 1'b0;
    logic        first_attempt = 1'b0;
    logic        motor_driven = 1'b0;
    logic [7:0]  bemf_mv = 8'h00;
    mcl_ctl_t    ctl;
    wire logic   speed_pulse_output;
    int          num_errors = 0;
    int          n_checks = 0;

    mcl_top mcl_top_i (
        .clk                (clk),
        .reset              (reset),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .speed_tick         (speed_tick),
        .loop_closed        (loop_closed),
        .first_attempt      (first_attempt),
        .motor_driven       (motor_driven),
        .bemf_mv            (bemf_mv),
        .ctl                (ctl),
        .speed_pulse_output (speed_pulse_output)
    );

    initial begin
        forever #2 clk = ~clk;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // limit in 0.5 Hz/s units, piecewise from the code table
    function automatic logic [17:0] exp_rate(input int c);
        if (c < 6) return (c == 0) ? 1 : (c == 1) ? 2 : c * 5 - 5;
        if (c < 11) return (c - 5) * 40;
        if (c < 20) return (c - 9) * 200;
        if (c < 25) return (c - 19) * 4000;
        return (c - 23) * 20000;
    endfunction : exp_rate

    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // write the config word, read it back at once, let ctl follow it
    task automatic wcfg(input logic [31:0] d);
        wr(MCL_CFG_A_OFS, d);
        reg_rd   <= 1'b1;
        reg_addr <= MCL_CFG_A_OFS;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, d & MCL_CFG_A_WMASK);
    endtask : wcfg

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs();
        logic [31:0] d;
        do_reset();
        rd(MCL_CFG_A_OFS, d);
        chk(d, MCL_CFG_A_RST);
        chk(ctl.decel_rate_half_hz, 18'h0_0001);
        wcfg(32'hFFFF_FFFF);
        chk({ctl.overmod_en, ctl.decel_unlimited, ctl.decel_src}, 4'hD);
        rd(MCL_CFG_A_OFS, d);
        chk(d, 32'h7FFF_FFFE);
        @(posedge clk);
        #1 chk(reg_rdata, 32'h0000_0000);
        wr(MCL_STATUS_OFS, 32'h0000_0000);
        wr(8'h10, 32'h0000_0000);
        rd(MCL_CFG_A_OFS, d);
        chk(d, 32'h7FFF_FFFE);
        rd(8'h10, d);
        chk(d, MCL_UNMAPPED_RD);
    endtask : t_regs

    task automatic chk_decel(input int c, input mcl_decel_src_t s);
        logic [31:0] d;
        chk(ctl.decel_src, s);
        chk(ctl.decel_unlimited, (c == 31));
        if (c != 31) chk(ctl.decel_rate_half_hz, exp_rate(c));
        rd(MCL_STATUS_OFS, d);
        chk(d[19:18], s);
        chk(d[20], (c == 31));
        if (c != 31) chk(d[17:0], exp_rate(c));
    endtask : chk_decel

    task automatic t_decel();
        logic [4:0] a;
        for (int c = 0; c < 32; c++) begin
            a = c[4:0] ^ 5'h15;
            wcfg({2'b00, a, 1'b0, c[4:0], 19'h0_0000});
            chk_decel(c, MCL_DEC_FROM_DECEL);
            wcfg({2'b00, a, 1'b1, c[4:0], 19'h0_0000});
            chk_decel(a, MCL_DEC_FROM_ACCEL);
            wcfg({2'b00, a, 1'b0, c[4:0], 19'h0_0008});
            chk(ctl.decel_src, MCL_DEC_BY_SURGE);
            chk(ctl.decel_rate_half_hz, 18'h0_0000);
        end
    endtask : t_decel

    task automatic t_freq();
        logic [31:0] d;
        logic [31:0] r;
        logic        ok;
        for (int f = 0; f < 16; f++) begin
            d = {13'h0000, f[3:0], f[0], 10'h000, f[3], f[1], f[2], 1'b1};
            ok = (f >= 1 && f <= 10);
            wcfg(d);
            chk(ctl.pwm_freq_valid, ok);
            chk(ctl.pwm_freq_khz, ok ? 10 + 5 * f : 0);
            chk(ctl.pwm_discontinuous, f[0]);
            chk(ctl.anti_surge_enable, f[3]);
            chk(ctl.deadtime_comp_enable, f[1]);
            chk(ctl.speed_regulator_bypass, f[2]);
            rd(MCL_CFG_A_OFS, r);
            chk(r, {d[31:1], 1'b0});
            rd(MCL_STATUS_OFS, r);
            chk(r[23:21], {1'b0, 1'b1, ok});
        end
    endtask : t_freq

    // 30 ticks, one every other cycle; count pulses seen at the pin
    task automatic sp(input logic [1:0] ph, input logic [3:0] dv, input logic pol,
                      input logic [2:0] th, input logic lc, input logic fa,
                      input logic md, input logic [7:0] bm, input int exp);
        int cnt;
        cnt = 0;
        do_reset();
        loop_closed   <= lc;
        first_attempt <= fa;
        motor_driven  <= md;
        bemf_mv       <= bm;
        wcfg({18'h0_0000, ph, dv, pol, th, 4'h0});
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            speed_tick <= (i < 60) && (i % 2 == 0);
            #1;
            if (speed_pulse_output === 1'b1) cnt++;
        end
        chk(cnt, exp);
    endtask : sp

    task automatic t_pulse();
        sp(2'h0, 4'h0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 8'h00, 30);
        sp(2'h0, 4'h1, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 8'h00, 30);
        sp(2'h0, 4'h2, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 8'h00, 15);
        sp(2'h0, 4'h3, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 8'h00, 10);
        sp(2'h0, 4'hF, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 8'h00, 2);
        sp(2'h1, 4'h0, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1, 8'h00, 0);
        sp(2'h1, 4'h0, 1'b0, 3'h0, 1'b1, 1'b0, 1'b1, 8'h00, 30);
        sp(2'h2, 4'h0, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1, 8'h00, 30);
        sp(2'h2, 4'h0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 8'h00, 0);
        sp(2'h3, 4'h0, 1'b0, 3'h0, 1'b1, 1'b1, 1'b1, 8'h00, 0);
        sp(2'h0, 4'h0, 1'b0, 3'h3, 1'b0, 1'b0, 1'b0, 8'hFF, 0);
        sp(2'h0, 4'h0, 1'b1, 3'h3, 1'b0, 1'b0, 1'b0, 8'h0A, 30);
        sp(2'h0, 4'h0, 1'b1, 3'h3, 1'b0, 1'b0, 1'b0, 8'h09, 0);
        sp(2'h0, 4'h0, 1'b1, 3'h3, 1'b0, 1'b0, 1'b1, 8'h00, 30);
        sp(2'h0, 4'h0, 1'b1, 3'h5, 1'b0, 1'b0, 1'b0, 8'h1E, 30);
        sp(2'h0, 4'h0, 1'b1, 3'h5, 1'b0, 1'b0, 1'b0, 8'h1D, 0);
        sp(2'h0, 4'h0, 1'b1, 3'h0, 1'b0, 1'b0, 1'b0, 8'h01, 30);
        sp(2'h0, 4'h0, 1'b1, 3'h0, 1'b0, 1'b0, 1'b0, 8'h00, 0);
        sp(2'h0, 4'h0, 1'b1, 3'h6, 1'b0, 1'b0, 1'b0, 8'hFF, 0);
    endtask : t_pulse

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        t_regs();
        t_decel();
        t_freq();
        t_pulse();
        summarize();
    end

    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        summarize();
    end

endmodule : test_motor_closed_loop_config_low
`default_nettype wire
